/* File: hdl/phy_event_interrupt_unit.sv */
// Event interrupt unit: mask, status and configuration registers and interrupt pin.
`timescale 1ns/1ps
`default_nettype none
module phy_event_interrupt_unit
	import phy_event_pkg::*;
(
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic [4:0] addr_i,
	input wire logic [15:0] wdata_i,
	input wire logic write_i,
	input wire logic read_i,
	output logic [15:0] rdata_o,
	input wire logic negotiation_fault_i,
	input wire logic rate_change_i,
	input wire logic duplex_change_i,
	input wire logic page_received_i,
	input wire logic negotiation_done_i,
	input wire logic link_change_i,
	input wire logic false_carrier_i,
	input wire logic crossover_change_i,
	input wire logic downshift_event_i,
	input wire logic sleep_change_i,
	input wire logic wake_packet_i,
	input wire logic mac_iface_error_i,
	input wire logic pair_polarity_flip_i,
	input wire logic jabber_i,
	input wire logic downshift_strap_i,
	input wire logic strap_variant_i,
	output logic interrupt_pin_o,
	output logic downshift_enable_o,
	output logic downshift_pair_energy_mode_o,
	output logic serial_mac_negotiation_enable_o,
	output logic downshift_to_slowest_enable_o,
	output logic [1:0] downshift_retry_limit_o
);

	// ---------------------------------------------------------------
	// Decode and merge helpers
	// ---------------------------------------------------------------
	// Every strobe compares the address through this one function, so the
	// register map cannot drift between the write and clear strobes; the read-data mux decodes addr_i in its own case.
	function automatic logic addr_hit(input logic [4:0] addr, input logic [4:0] target);
		return addr == target;
	endfunction : addr_hit

	// Only the writable configuration bits take new data; the reserved bits and
	// the read-only retry field keep what they hold.
	function automatic logic [15:0] merge_config(input logic [15:0] old_value,
		input logic [15:0] data);
		return (old_value & ~CONFIG_RW_BITS) | (data & CONFIG_RW_BITS);
	endfunction : merge_config

	// Reserved positions never reach the event path or the mask.
	function automatic logic [15:0] keep_events(input logic [15:0] value);
		return value & EVENT_BITS;
	endfunction : keep_events

	// The pin equals the polarity bit while idle and its inverse while pending.
	function automatic logic pin_level(input logic pending_in, input logic active_low);
		return pending_in ^ active_low;
	endfunction : pin_level

	// ---------------------------------------------------------------
	// Input synchronisation and event detection
	// ---------------------------------------------------------------
	// Events arrive as pulses or levels from other logic; a rising edge of each
	// synchronised line counts as one event.
	// A line that is already high when reset releases counts as one event, since
	// the detector cannot tell a level held all along from a new one.
	logic [16:0] raw;
	logic [16:0] sync;
	logic [15:0] event_level;
	logic [15:0] event_prev;
	logic [15:0] next_event_prev;
	logic [15:0] event_pulse;
	logic strap_level;

	// Bit 16 carries the strap; bits 15:0 line up with the status register.
	assign raw = {
		downshift_strap_i,
		negotiation_fault_i,
		rate_change_i,
		duplex_change_i,
		page_received_i,
		negotiation_done_i,
		link_change_i,
		1'b0,
		false_carrier_i,
		1'b0,
		crossover_change_i,
		downshift_event_i,
		sleep_change_i,
		wake_packet_i,
		mac_iface_error_i,
		pair_polarity_flip_i,
		jabber_i
	};

	pin_sync u_sync (
		.clk_i(clk_i),
		.async_i(raw),
		.sync_o(sync)
	);

	assign event_level = keep_events(sync[15:0]);
	assign strap_level = sync[16];
	assign event_pulse = event_level & ~event_prev;

	always_comb begin
		next_event_prev = event_level;
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			event_prev <= 16'h0000;
		end else begin
			event_prev <= next_event_prev;
		end
	end

	// ---------------------------------------------------------------
	// Register strobes
	// ---------------------------------------------------------------
	// Writes to the status register or to unmapped addresses decode to nothing
	// and are dropped.
	logic write_mask;
	logic write_config;
	logic read_status;

	assign write_mask = write_i && addr_hit(addr_i, ADDR_EVENT_MASK);
	assign write_config = write_i && addr_hit(addr_i, ADDR_CONFIG);
	assign read_status = read_i && addr_hit(addr_i, ADDR_EVENT_STATUS);

	// ---------------------------------------------------------------
	// Status register
	// ---------------------------------------------------------------
	// The read that returns the status also clears it; an event that lands in
	// the same cycle survives the clear, so no event is lost.
	logic [15:0] status;

	event_latch u_latch (
		.clk_i(clk_i),
		.reset_i(reset_i),
		.event_i(event_pulse),
		.clear_i(read_status),
		.status_o(status)
	);

	// ---------------------------------------------------------------
	// Mask register
	// ---------------------------------------------------------------
	// Mask bits 9 and 7 cannot be set, so they always read back as zero.
	logic [15:0] mask;
	logic [15:0] next_mask;

	always_comb begin
		next_mask = mask;
		if (write_mask) begin
			next_mask = keep_events(wdata_i);
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			mask <= MASK_RESET;
		end else begin
			mask <= next_mask;
		end
	end

	// ---------------------------------------------------------------
	// Configuration register
	// ---------------------------------------------------------------
	// The strap is caught once, on the first edge after reset release; the
	// synchroniser runs through reset, so its level has settled by then.
	// A configuration write in that same cycle still wins, as software wrote later.
	logic [15:0] config_reg;
	logic [15:0] next_config;
	logic strap_pending;
	logic next_strap_pending;

	always_comb begin
		next_config = config_reg;
		next_strap_pending = 1'b0;
		if (strap_pending) begin
			next_config[CFG_DOWNSHIFT_EN] = strap_variant_i & strap_level;
		end
		if (write_config) begin
			next_config = merge_config(next_config, wdata_i);
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			config_reg <= CONFIG_RESET;
			strap_pending <= 1'b1;
		end else begin
			config_reg <= next_config;
			strap_pending <= next_strap_pending;
		end
	end

	// ---------------------------------------------------------------
	// Read port
	// ---------------------------------------------------------------
	logic [15:0] rdata;
	logic [15:0] next_rdata;

	// Idle cycles and reads of unmapped addresses return zero, so the data bus
	// never shows a stale word outside the cycle after a read.
	always_comb begin
		next_rdata = 16'h0000;
		if (read_i) begin
			unique case (addr_i)
				ADDR_EVENT_MASK: next_rdata = mask;
				ADDR_EVENT_STATUS: next_rdata = status;
				ADDR_CONFIG: next_rdata = config_reg;
				default: next_rdata = 16'h0000;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			rdata <= 16'h0000;
		end else begin
			rdata <= next_rdata;
		end
	end

	// ---------------------------------------------------------------
	// Interrupt pin
	// ---------------------------------------------------------------
	// The pin follows the latched status, so it deasserts once reads clear, or a mask write disables, every
	// enabled pending bit; the one-cycle register delay keeps it glitch free.
	logic pending;
	logic pin;
	logic next_pin;

	assign pending = |(status & mask);

	always_comb begin
		next_pin = pin_level(pending, config_reg[CFG_POLARITY]);
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			pin <= CONFIG_RESET[CFG_POLARITY];
		end else begin
			pin <= next_pin;
		end
	end

	// ---------------------------------------------------------------
	// Configuration outputs
	// ---------------------------------------------------------------
	// Outputs load from the next register value, so they never lag the word that
	// a read in the following cycle returns.
	logic downshift_enable;
	logic next_downshift_enable;
	logic pair_energy_mode;
	logic next_pair_energy_mode;
	logic serial_negotiation;
	logic next_serial_negotiation;
	logic slowest_enable;
	logic next_slowest_enable;
	logic [1:0] retry_limit;
	logic [1:0] next_retry_limit;

	always_comb begin
		next_downshift_enable = next_config[CFG_DOWNSHIFT_EN];
		next_pair_energy_mode = next_config[CFG_PAIR_ENERGY];
		next_serial_negotiation = next_config[CFG_SERIAL_NEG];
		next_slowest_enable = next_config[CFG_SLOWEST];
		next_retry_limit = next_config[CFG_RETRY_LO+1:CFG_RETRY_LO];
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			downshift_enable <= CONFIG_RESET[CFG_DOWNSHIFT_EN];
			pair_energy_mode <= CONFIG_RESET[CFG_PAIR_ENERGY];
			serial_negotiation <= CONFIG_RESET[CFG_SERIAL_NEG];
			slowest_enable <= CONFIG_RESET[CFG_SLOWEST];
			retry_limit <= CONFIG_RESET[CFG_RETRY_LO+1:CFG_RETRY_LO];
		end else begin
			downshift_enable <= next_downshift_enable;
			pair_energy_mode <= next_pair_energy_mode;
			serial_negotiation <= next_serial_negotiation;
			slowest_enable <= next_slowest_enable;
			retry_limit <= next_retry_limit;
		end
	end

	assign rdata_o = rdata;
	assign interrupt_pin_o = pin;
	assign downshift_enable_o = downshift_enable;
	assign downshift_pair_energy_mode_o = pair_energy_mode;
	assign serial_mac_negotiation_enable_o = serial_negotiation;
	assign downshift_to_slowest_enable_o = slowest_enable;
	assign downshift_retry_limit_o = retry_limit;
endmodule : phy_event_interrupt_unit
`default_nettype wire

/* File: inc/phy_event_pkg.sv */
// Constants, register map and field layout of the event interrupt unit.
// How it works
// - A status bit sets whenever its event occurs, whatever its mask bit says.
// - Each status bit latches high on its event, is cleared by the read that reports it, and resets to 0.
// - Bits 15..10 report negotiation fault, rate change, duplex change, page received, negotiation done and link change.
// - Bits 8, 6, 5, 4, 3 report false carrier, crossover change, downshift event, sleep change and wake packet.
// - Bits 2, 1, 0 report MAC interface error (parallel or serial), pair polarity flip and jabber.
// - Status bits 9 and 7 are reserved and read as zero.
// - Mask bits 2, 1, 0 are read-write enables for MAC error, polarity flip and jabber, resetting to 0.
// - The other mask bits enable the events at the same positions; mask bits 9 and 7 are reserved.
// - An interrupt is signalled only for an event whose mask bit is set.
// - Configuration bit 13 sets the pin polarity, 1 active low (reset value) and 0 active high.
// - Configuration field 11:10 is a read-only retry limit 8/4/2/1, reset 10.
// - Configuration bit 9 enables downshift; it resets to 0 or to a strapped value by package variant.
// - Configuration bit 8 enables pair-energy downshift mode, reset 1.
// - Configuration bit 7 enables serial MAC negotiation, read-write, reset 1.
// - Configuration bits 15:14 and 12 are reserved read-only, 15:14 read 0, field 5:0 resets to 0 0111.
package phy_event_pkg;
	localparam logic [4:0] ADDR_EVENT_MASK = 5'h12;
	localparam logic [4:0] ADDR_EVENT_STATUS = 5'h13;
	localparam logic [4:0] ADDR_CONFIG = 5'h14;
	localparam logic [15:0] EVENT_BITS = 16'hFD7F;
	localparam logic [15:0] MASK_RESET = 16'h0000;
	localparam logic [15:0] STATUS_RESET = 16'h0000;
	localparam logic [15:0] CONFIG_RW_BITS = 16'h23C0;
	localparam logic [15:0] CONFIG_RESET = 16'h29C7;
	localparam int CFG_POLARITY = 13;
	localparam int CFG_DOWNSHIFT_EN = 9;
	localparam int CFG_PAIR_ENERGY = 8;
	localparam int CFG_SERIAL_NEG = 7;
	localparam int CFG_SLOWEST = 6;
	localparam int CFG_RETRY_LO = 10;
	localparam int EVENT_COUNT = 16;
endpackage : phy_event_pkg

/* File: hdl/event_latch.sv */
// Sticky clear-on-read event status bits.
`timescale 1ns/1ps
`default_nettype none
module event_latch
	import phy_event_pkg::*;
(
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic [15:0] event_i,
	input wire logic clear_i,
	output logic [15:0] status_o
);
	logic [15:0] status;
	logic [15:0] next_status;

	// A new event in the clearing cycle survives the clear, so nothing is lost.
	always_comb begin
		next_status = clear_i ? 16'h0000 : status;
		next_status = (next_status | event_i) & EVENT_BITS;
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			status <= STATUS_RESET;
		end else begin
			status <= next_status;
		end
	end

	assign status_o = status;
endmodule : event_latch
`default_nettype wire

/* File: hdl/pin_sync.sv */
// Two-flop synchroniser for pin inputs.
`timescale 1ns/1ps
`default_nettype none
module pin_sync (
	input wire logic clk_i,
	input wire logic [16:0] async_i,
	output logic [16:0] sync_o
);
	logic [16:0] stage1;
	logic [16:0] stage2;
	logic [16:0] next_stage1;
	logic [16:0] next_stage2;

	always_comb begin
		next_stage1 = async_i;
		next_stage2 = stage1;
	end

	// No reset: the stages keep tracking the pins through reset, so a strap level
	// has already settled in the second stage when reset releases.
	always_ff @(posedge clk_i) begin
		stage1 <= next_stage1;
		stage2 <= next_stage2;
	end

	assign sync_o = stage2;
endmodule : pin_sync
`default_nettype wire

/* File: dv/phy_event_checker.sv */
// Port-level assertions for the event interrupt unit.
`timescale 1ns/1ps
`default_nettype none
module phy_event_checker
	import phy_event_pkg::*;
(
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic [4:0] addr_i,
	input wire logic [15:0] wdata_i,
	input wire logic write_i,
	input wire logic read_i,
	input wire logic [15:0] rdata_o,
	input wire logic jabber_i,
	input wire logic interrupt_pin_o,
	input wire logic downshift_enable_o,
	input wire logic downshift_pair_energy_mode_o,
	input wire logic serial_mac_negotiation_enable_o,
	input wire logic downshift_to_slowest_enable_o,
	input wire logic [1:0] downshift_retry_limit_o
);
	// --------------------------------------------
	// Shadow of the mask and polarity as written
	// --------------------------------------------
	logic [15:0] mask_q;
	logic pol;
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			mask_q <= 16'h0000;
			pol <= 1'b1;
		end else if (write_i) begin
			if (addr_i == ADDR_EVENT_MASK) mask_q <= wdata_i & EVENT_BITS;
			if (addr_i == ADDR_CONFIG) pol <= wdata_i[CFG_POLARITY];
		end
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (reset_i);
	sequence cfg_wr_s;
		write_i && addr_i == ADDR_CONFIG ##1 !write_i;
	endsequence
	sequence rd_s(a);
		read_i && addr_i == a;
	endsequence
	a_status_reserved: assert property (rd_s(ADDR_EVENT_STATUS) |=> rdata_o[9] == 1'b0 && rdata_o[7] == 1'b0)
		else $error("reserved status bit set");
	a_mask_reserved: assert property (rd_s(ADDR_EVENT_MASK) |=> rdata_o[9] == 1'b0 && rdata_o[7] == 1'b0)
		else $error("reserved mask bit set");
	a_cfg_reserved: assert property (rd_s(ADDR_CONFIG) |=> rdata_o[15:14] == 2'h0 && !rdata_o[12] && rdata_o[5:0] == 6'h07)
		else $error("reserved config bits wrong");
	a_retry_read: assert property (rd_s(ADDR_CONFIG) |=> rdata_o[11:10] == 2'h2)
		else $error("retry field read wrong");
	a_retry_pin: assert property (downshift_retry_limit_o == 2'h2)
		else $error("retry output wrong");
	a_cfg_copy: assert property (cfg_wr_s |=> {downshift_enable_o, downshift_pair_energy_mode_o, serial_mac_negotiation_enable_o, downshift_to_slowest_enable_o} == $past(wdata_i[9:6], 2))
		else $error("config outputs not updated");
	a_pol_readback: assert property (rd_s(ADDR_CONFIG) |=> rdata_o[13] == $past(pol))
		else $error("polarity bit read wrong");
	a_pin_quiet: assert property ((mask_q == 16'h0000 && $stable(pol))[*3] |-> interrupt_pin_o == pol)
		else $error("pin active with all events masked");
	a_jabber_pin: assert property ($rose(jabber_i) && mask_q[0] |-> ##[1:6] interrupt_pin_o != pol)
		else $error("enabled event did not raise pin");
endmodule : phy_event_checker
bind phy_event_interrupt_unit phy_event_checker u_phy_event_checker (.*);
`default_nettype wire

/* File: dv/mgmt_host.sv */
// Management host model driving the register port.
`timescale 1ns/1ps
`default_nettype none
module mgmt_host (
	input wire logic clk_i,
	input wire logic [15:0] rdata_i,
	output logic [4:0] addr_o,
	output logic [15:0] wdata_o,
	output logic write_o,
	output logic read_o
);
	initial begin
		addr_o = 5'h00;
		wdata_o = 16'h0000;
		write_o = 1'b0;
		read_o = 1'b0;
	end
	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		@(posedge clk_i);
		addr_o <= a;
		wdata_o <= d;
		write_o <= 1'b1;
		@(posedge clk_i);
		write_o <= 1'b0;
	endtask : wr
	// Read data stand only in the cycle after the strobe, so sample it there.
	task automatic rd(input logic [4:0] a, output logic [15:0] d);
		@(posedge clk_i);
		addr_o <= a;
		read_o <= 1'b1;
		@(posedge clk_i);
		read_o <= 1'b0;
		#1 d = rdata_i;
	endtask : rd
endmodule : mgmt_host
`default_nettype wire

/* File: dv/tb.sv */
// Self-checking bench for the event interrupt unit.
`timescale 1ns/1ps
`default_nettype none
module tb
	import phy_event_pkg::*;
;
	logic clk_i = 1'b0;
	logic reset_i = 1'b1;
	logic strap = 1'b0;
	logic variant = 1'b0;
	logic [15:0] ev = 16'h0000;
	logic [4:0] addr;
	logic [15:0] wdata, rdata, d, m, c, e;
	logic write, read, pin, ds_en, pair, serial, slow;
	logic [1:0] retry;
	logic [31:0] seed = 32'h77AC49C2;
	int err_count = 0;
	int checked = 0;
	int cyc = 0;
	initial forever #2.5 clk_i = ~clk_i;
	mgmt_host u_mgmt_host (.clk_i(clk_i), .rdata_i(rdata), .addr_o(addr), .wdata_o(wdata),
		.write_o(write), .read_o(read));
	phy_event_interrupt_unit u_phy_event_interrupt_unit (.clk_i(clk_i), .reset_i(reset_i),
		.addr_i(addr), .wdata_i(wdata), .write_i(write), .read_i(read), .rdata_o(rdata),
		.negotiation_fault_i(ev[15]), .rate_change_i(ev[14]), .duplex_change_i(ev[13]),
		.page_received_i(ev[12]), .negotiation_done_i(ev[11]), .link_change_i(ev[10]),
		.false_carrier_i(ev[8]), .crossover_change_i(ev[6]), .downshift_event_i(ev[5]),
		.sleep_change_i(ev[4]), .wake_packet_i(ev[3]), .mac_iface_error_i(ev[2]),
		.pair_polarity_flip_i(ev[1]), .jabber_i(ev[0]), .downshift_strap_i(strap),
		.strap_variant_i(variant), .interrupt_pin_o(pin), .downshift_enable_o(ds_en),
		.downshift_pair_energy_mode_o(pair), .serial_mac_negotiation_enable_o(serial),
		.downshift_to_slowest_enable_o(slow), .downshift_retry_limit_o(retry));
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : xs
	function automatic logic [15:0] exp_cfg(input logic [15:0] w);
		return (w & CONFIG_RW_BITS) | (CONFIG_RESET & ~CONFIG_RW_BITS);
	endfunction : exp_cfg
	task chk(input logic [15:0] s, input logic [15:0] x);
		checked++;
		if (s !== x) begin
			err_count++;
			$display("MISMATCH %0t got %h expected %h", $time, s, x);
		end
	endtask : chk
	task wrap_up();
		$display("checked %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : wrap_up
	// A hung handshake would stall the run; the ceiling is a few times the expected length.
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			err_count++;
			wrap_up();
		end
	end
	initial begin
		// Variant 0 ignores a high strap; variant 1 follows the strap either way.
		for (int v = 0; v < 3; v++) begin
			reset_i <= 1'b1;
			strap <= ~v[1];
			variant <= v[0] | v[1];
			repeat (3) @(posedge clk_i);
			reset_i <= 1'b0;
			u_mgmt_host.rd(ADDR_CONFIG, d);
			chk(d, CONFIG_RESET | {6'h00, v[0], 9'h000});
			u_mgmt_host.rd(ADDR_EVENT_MASK, d);
			chk(d, MASK_RESET);
			u_mgmt_host.rd(ADDR_EVENT_STATUS, d);
			chk(d, STATUS_RESET);
			chk({9'h000, ds_en, pair, serial, slow, retry, pin}, {9'h000, v[0], 6'h3D});
			$display("test reset variant %0d done", v);
		end
		// Single events under a full mask first, then random masks, events and config.
		for (int i = 0; i < 40; i++) begin
			m = (i < 16) ? 16'hFFFF : 16'(xs());
			e = ((i < 16) ? 16'h0001 << i : 16'(xs())) & EVENT_BITS;
			c = (i < 16) ? CONFIG_RESET : 16'(xs());
			u_mgmt_host.wr(ADDR_CONFIG, c);
			u_mgmt_host.wr(ADDR_EVENT_MASK, m);
			u_mgmt_host.wr(ADDR_EVENT_STATUS, 16'hFFFF);
			u_mgmt_host.rd(ADDR_EVENT_MASK, d);
			chk(d, m & EVENT_BITS);
			u_mgmt_host.rd(ADDR_CONFIG, d);
			chk(d, exp_cfg(c));
			chk({12'h000, ds_en, pair, serial, slow}, {12'h000, c[9:6]});
			@(posedge clk_i);
			ev <= e;
			repeat (3) @(posedge clk_i);
			ev <= 16'h0000;
			repeat (3) @(posedge clk_i);
			#1 chk({15'h0000, pin}, {15'h0000, |(e & m) ^ c[13]});
			u_mgmt_host.rd(ADDR_EVENT_STATUS, d);
			chk(d, e);
			repeat (2) @(posedge clk_i);
			#1 chk({15'h0000, pin}, {15'h0000, c[13]});
			u_mgmt_host.rd(ADDR_EVENT_STATUS, d);
			chk(d, 16'h0000);
		end
		$display("test events done");
		u_mgmt_host.rd(5'h00, d);
		chk(d, 16'h0000);
		$display("test unmapped done");
		wrap_up();
	end
endmodule : tb
`default_nettype wire
